// File: rtl/afe_regs_map.svh
// Register offsets, field positions, reset values and timing values in ns of the register group
`ifndef AFE_REGS_MAP_SVH
`define AFE_REGS_MAP_SVH

`define AFE_ADDR_W 5
`define AFE_ADDR_FIRST 5'h00
`define AFE_ADDR_DATA_LAST 5'h07
`define AFE_ADDR_MOD 5'h08
`define AFE_ADDR_PHASE_LOW 5'h0A
`define AFE_ADDR_GAIN 5'h0B
`define AFE_ADDR_STATUS 5'h0C
`define AFE_ADDR_GRP_B_FIRST 5'h0B
`define AFE_ADDR_CAL_FIRST 5'h0F
`define AFE_ADDR_LAST 5'h1F
`define AFE_ADDR_WR_FIRST 5'h09

`define AFE_PHASE_B_MSB 23
`define AFE_PHASE_B_LSB 12
`define AFE_PHASE_A_MSB 11
`define AFE_PHASE_A_LSB 0

`define AFE_CTRL_MSB 23
`define AFE_CTRL_LSB 14
`define AFE_FLAGS_MSB 7
`define AFE_FLAGS_LSB 0

`define AFE_STATUS_CTRL_RESET 10'h2A4
`define AFE_PHASE_RESET 24'h00_0000
`define AFE_GAIN_RESET 24'h00_0000
`define AFE_FLAGS_RESET 8'hFF

`define AFE_GAIN_CODE_MAX 3'h5
`define AFE_GAIN_UNITY 3'h0
`define AFE_UNLOCK_KEY 8'hA5
`define AFE_READY_PULSE_NS 40
`define AFE_CLOCK_NS 10

`endif

// File: rtl/afe_regs_pkg.sv
// Types shared by the register group modules
package afe_regs_pkg;
   typedef struct packed {
      logic [1:0] read_inc;
      logic write_inc;
      logic pin_idle_drive;
      logic ready_link;
      logic crc_width;
      logic [1:0] out_width;
      logic comm_crc_enable;
      logic crc_int_enable;
   } afe_comm_cfg_t;

   typedef struct packed {
      logic [11:0] delay_pair_2_3;
      logic [11:0] delay_pair_0_1;
   } afe_phase_t;
endpackage

// File: rtl/afe_ready_flag.sv
// One channel ready flag: cleared by new data, set again by a status read
`timescale 1ns/1ps
module afe_ready_flag (
   input wire logic clock, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic data_latch, // New result latched for this channel
   input wire logic status_read, // Status register read
   output logic flag // 1 while no new data
);
   // New data wins over a simultaneous status read so the event is not lost
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b1;
      end else if (data_latch) begin
         flag <= 1'b0;
      end else if (status_read) begin
         flag <= 1'b1;
      end
   end
endmodule

// File: rtl/afe_addr_step.sv
// Next address of the serial access counter for each stepping mode
`timescale 1ns/1ps
`include "afe_regs_map.svh"
module afe_addr_step (
   input wire logic [`AFE_ADDR_W-1:0] addr, // Address of the current access
   input wire logic is_write, // Current access is a write
   input wire logic [1:0] read_inc, // Read stepping mode
   input wire logic write_inc, // Write stepping enable
   output logic [`AFE_ADDR_W-1:0] next_addr // Address of the following access
);
   logic [`AFE_ADDR_W-1:0] grp_lo;
   logic [`AFE_ADDR_W-1:0] grp_hi;
   logic [`AFE_ADDR_W-1:0] plus_one;

   always_comb begin
      plus_one = addr + `AFE_ADDR_W'(1);
      // Groups: data block, modulator with phases, gain through config, cal pairs, lock
      if (addr <= `AFE_ADDR_DATA_LAST) begin
         grp_lo = `AFE_ADDR_FIRST;
         grp_hi = `AFE_ADDR_DATA_LAST;
      end else if (addr < `AFE_ADDR_GRP_B_FIRST) begin
         grp_lo = `AFE_ADDR_MOD;
         grp_hi = `AFE_ADDR_PHASE_LOW;
      end else if (addr < `AFE_ADDR_CAL_FIRST) begin
         grp_lo = `AFE_ADDR_GRP_B_FIRST;
         grp_hi = `AFE_ADDR_CAL_FIRST - `AFE_ADDR_W'(1);
      end else if (addr == `AFE_ADDR_LAST) begin
         grp_lo = `AFE_ADDR_LAST;
         grp_hi = `AFE_ADDR_LAST;
      end else begin
         grp_lo = addr - `AFE_ADDR_W'((addr - `AFE_ADDR_CAL_FIRST) & `AFE_ADDR_W'(1));
         grp_hi = grp_lo + `AFE_ADDR_W'(1);
      end
      next_addr = addr;
      if (is_write) begin
         if (write_inc) begin
            if (addr == `AFE_ADDR_LAST || addr < `AFE_ADDR_WR_FIRST) begin
               next_addr = `AFE_ADDR_WR_FIRST;
            end else begin
               next_addr = plus_one;
            end
         end
      end else begin
         unique case (read_inc)
            2'b11: next_addr = (addr == `AFE_ADDR_LAST) ? `AFE_ADDR_FIRST : plus_one;
            2'b10: begin
               if (addr == `AFE_ADDR_DATA_LAST) begin
                  next_addr = `AFE_ADDR_FIRST;
               end else if (addr == `AFE_ADDR_LAST) begin
                  next_addr = `AFE_ADDR_MOD;
               end else begin
                  next_addr = plus_one;
               end
            end
            2'b01: next_addr = (addr == grp_hi) ? grp_lo : plus_one;
            2'b00: next_addr = addr;
         endcase
      end
   end
endmodule

// File: rtl/afe_regs.sv
// Phase, gain and status/communication registers with ready pin control
`timescale 1ns/1ps
`include "afe_regs_map.svh"
module afe_regs
   import afe_regs_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int READY_PULSE_CYCLES = (`AFE_READY_PULSE_NS + `AFE_CLOCK_NS - 1) / `AFE_CLOCK_NS
) (
   input wire logic clock, // System clock, 100 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic acc_valid, // One register access this cycle
   input wire logic acc_start, // Load acc_addr into the address counter
   input wire logic [`AFE_ADDR_W-1:0] acc_addr, // Start address
   input wire logic acc_write, // Access is a write
   input wire logic [23:0] acc_wdata, // Write data
   input wire logic [CHANNELS-1:0] chan_active, // Channels not in reset or shutdown
   input wire logic [CHANNELS-1:0] chan_data_evt, // Converter result ready, per channel
   input wire logic cfg_crc_error, // Configuration checksum mismatch
   input wire logic lock_write, // Lock field written
   input wire logic [7:0] lock_value, // Value written to the lock field
   output logic [23:0] acc_rdata, // Read data
   output logic acc_rvalid, // Read data valid pulse
   output logic [`AFE_ADDR_W-1:0] cur_addr, // Address counter
   output afe_phase_t phase, // Channel pair delays in modulator clocks
   output logic [3*CHANNELS-1:0] gain_log2, // Effective gain exponent per channel
   output afe_comm_cfg_t comm_cfg, // Serial port and pin configuration
   output logic [CHANNELS-1:0] adc_restart, // Restart pulse per channel
   output logic [CHANNELS-1:0] data_latch, // Latch result into data register
   output logic [CHANNELS-1:0] ready_flags, // Per-channel flags, 1 = not ready
   output logic ready_pin_out, // Ready pin level, active low
   output logic ready_pin_oe, // Ready pin driven
   output logic crc_irq // Checksum interrupt held
);
   localparam int PW = $clog2(READY_PULSE_CYCLES + 1);

   logic [`AFE_ADDR_W-1:0] addr_now;
   logic [`AFE_ADDR_W-1:0] next_addr;
   logic [3*CHANNELS-1:0] gain_raw;
   logic wr_now;
   logic rd_now;
   logic status_read;
   logic [CHANNELS-1:0] pending;
   logic [CHANNELS-1:0] next_pending;
   logic link_fire;
   logic [CHANNELS-1:0] next_latch;
   logic [PW-1:0] pulse_cnt;
   logic unlock;

   assign addr_now = acc_start ? acc_addr : cur_addr;
   assign wr_now = acc_valid && acc_write;
   assign rd_now = acc_valid && !acc_write;
   assign unlock = lock_write && (lock_value == `AFE_UNLOCK_KEY);

   afe_addr_step u_step (
      .addr(addr_now),
      .is_write(acc_write),
      .read_inc(comm_cfg.read_inc),
      .write_inc(comm_cfg.write_inc),
      .next_addr(next_addr)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur_addr <= `AFE_ADDR_FIRST;
      end else if (acc_valid) begin
         cur_addr <= next_addr;
      end else if (acc_start) begin
         cur_addr <= acc_addr;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase <= `AFE_PHASE_RESET;
      end else if (wr_now && addr_now == `AFE_ADDR_PHASE_LOW) begin
         phase.delay_pair_2_3 <= acc_wdata[`AFE_PHASE_B_MSB:`AFE_PHASE_B_LSB];
         phase.delay_pair_0_1 <= acc_wdata[`AFE_PHASE_A_MSB:`AFE_PHASE_A_LSB];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         adc_restart <= '0;
      end else if (wr_now && addr_now == `AFE_ADDR_PHASE_LOW) begin
         adc_restart <= chan_active;
      end else begin
         adc_restart <= '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gain_raw <= `AFE_GAIN_RESET;
      end else if (wr_now && addr_now == `AFE_ADDR_GAIN) begin
         gain_raw <= acc_wdata[3*CHANNELS-1:0];
      end
   end

   // reserved codes fall back to unity gain
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gain_log2 <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (gain_raw[3*i +: 3] > `AFE_GAIN_CODE_MAX) begin
               gain_log2[3*i +: 3] <= `AFE_GAIN_UNITY;
            end else begin
               gain_log2[3*i +: 3] <= gain_raw[3*i +: 3];
            end
         end
      end
   end

   // control fields; reserved bits are not stored
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         comm_cfg <= `AFE_STATUS_CTRL_RESET;
      end else if (wr_now && addr_now == `AFE_ADDR_STATUS) begin
         comm_cfg <= acc_wdata[`AFE_CTRL_MSB:`AFE_CTRL_LSB];
      end
   end

   // unimplemented and reserved bits read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_rdata <= '0;
         acc_rvalid <= 1'b0;
      end else begin
         acc_rvalid <= rd_now;
         if (rd_now) begin
            unique case (addr_now)
               `AFE_ADDR_PHASE_LOW: acc_rdata <= {phase.delay_pair_2_3, phase.delay_pair_0_1};
               `AFE_ADDR_GAIN: acc_rdata <= gain_raw;
               `AFE_ADDR_STATUS: acc_rdata <= {comm_cfg, 6'h00, ready_flags};
               default: acc_rdata <= '0;
            endcase
         end
      end
   end

   assign status_read = rd_now && addr_now == `AFE_ADDR_STATUS;

   // link collects every active channel before one joint latch
   always_comb begin
      next_pending = pending | chan_data_evt;
      link_fire = comm_cfg.ready_link && (chan_active != '0)
                  && ((next_pending & chan_active) == chan_active);
      if (!comm_cfg.ready_link) begin
         next_latch = chan_data_evt;
      end else if (link_fire) begin
         next_latch = chan_active;
      end else begin
         next_latch = '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pending <= '0;
      end else if (!comm_cfg.ready_link || link_fire) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         data_latch <= '0;
      end else begin
         data_latch <= next_latch;
      end
   end

   // flags cleared by a latched result
   for (genvar c = 0; c < CHANNELS; c++) begin : g_flag
      afe_ready_flag u_flag (
         .clock(clock),
         .rst_n(rst_n),
         .data_latch(data_latch[c]),
         .status_read(status_read),
         .flag(ready_flags[c])
      );
   end

   // sticky checksum interrupt; a new error wins over unlock
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crc_irq <= 1'b0;
      end else if (comm_cfg.crc_int_enable && cfg_crc_error) begin
         crc_irq <= 1'b1;
      end else if (unlock) begin
         crc_irq <= 1'b0;
      end
   end

   // Pulse length counted so short modulator periods still give a visible low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= '0;
      end else if (next_latch != '0) begin
         pulse_cnt <= PW'(READY_PULSE_CYCLES);
      end else if (pulse_cnt != '0) begin
         pulse_cnt <= pulse_cnt - PW'(1);
      end
   end

   // pin: low for pulse or interrupt, idle high or released
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ready_pin_out <= 1'b1;
         ready_pin_oe <= 1'b0;
      end else if (crc_irq || pulse_cnt != '0) begin
         ready_pin_out <= 1'b0;
         ready_pin_oe <= 1'b1;
      end else begin
         ready_pin_out <= 1'b1;
         ready_pin_oe <= comm_cfg.pin_idle_drive;
      end
   end

   property p_restart;
      @(posedge clock) disable iff (!rst_n)
      (wr_now && addr_now == `AFE_ADDR_PHASE_LOW) |=> (adc_restart == $past(chan_active));
   endproperty
   a_restart: assert property (p_restart) else $error("phase write did not restart active channels");

   property p_gain_legal;
      @(posedge clock) disable iff (!rst_n)
      (gain_raw[3*CHANNELS-1 -: 3] > `AFE_GAIN_CODE_MAX) |=> (gain_log2[3*CHANNELS-1 -: 3] == `AFE_GAIN_UNITY);
   endproperty
   a_gain_legal: assert property (p_gain_legal) else $error("reserved gain code not unity");

   property p_write_hold;
      @(posedge clock) disable iff (!rst_n)
      (wr_now && !comm_cfg.write_inc) |=> (cur_addr == $past(addr_now));
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("fixed write address moved");

   property p_idle_release;
      @(posedge clock) disable iff (!rst_n)
      (!crc_irq && pulse_cnt == '0 && !comm_cfg.pin_idle_drive) |=> (!ready_pin_oe);
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("idle pin driven while released");

   property p_link_all;
      @(posedge clock) disable iff (!rst_n)
      link_fire |=> (data_latch == $past(chan_active)) ##1 (ready_pin_out == 1'b0);
   endproperty
   a_link_all: assert property (p_link_all) else $error("linked latch not joint");

   property p_irq_hold;
      @(posedge clock) disable iff (!rst_n)
      (crc_irq && !unlock) |=> crc_irq ##1 (!ready_pin_out && ready_pin_oe);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("checksum interrupt released early");

   property p_irq_off;
      @(posedge clock) disable iff (!rst_n)
      (!comm_cfg.crc_int_enable && !crc_irq) |=> !crc_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt raised while disabled");

   property p_unimpl_zero;
      @(posedge clock) disable iff (!rst_n)
      status_read |=> (acc_rvalid && acc_rdata[13:8] == 6'h00);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("status reserved bits not zero");

   property p_read_rearm;
      @(posedge clock) disable iff (!rst_n)
      (status_read && data_latch == '0) |=> (ready_flags == `AFE_FLAGS_RESET);
   endproperty
   a_read_rearm: assert property (p_read_rearm) else $error("status read did not set flags");

   property p_flag_clear;
      @(posedge clock) disable iff (!rst_n)
      (next_latch[0]) |=> ##1 (ready_flags[0] == 1'b0);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("new data did not clear flag");

   property p_phase_load;
      @(posedge clock) disable iff (!rst_n)
      (wr_now && addr_now == `AFE_ADDR_PHASE_LOW)
         |=> (phase.delay_pair_2_3 == $past(acc_wdata[`AFE_PHASE_B_MSB:`AFE_PHASE_B_LSB]))
            && (phase.delay_pair_0_1 == $past(acc_wdata[`AFE_PHASE_A_MSB:`AFE_PHASE_A_LSB]));
   endproperty
   a_phase_load: assert property (p_phase_load) else $error("delay fields not stored");

   property p_gain_load;
      @(posedge clock) disable iff (!rst_n)
      (wr_now && addr_now == `AFE_ADDR_GAIN) |=> (gain_raw == $past(acc_wdata[3*CHANNELS-1:0]));
   endproperty
   a_gain_load: assert property (p_gain_load) else $error("gain codes not stored");

   property p_read_fixed;
      @(posedge clock) disable iff (!rst_n)
      (rd_now && comm_cfg.read_inc == 2'b00) |=> (cur_addr == $past(addr_now));
   endproperty
   a_read_fixed: assert property (p_read_fixed) else $error("fixed read address moved");

   property p_unlinked_latch;
      @(posedge clock) disable iff (!rst_n)
      !comm_cfg.ready_link |=> (data_latch == $past(chan_data_evt));
   endproperty
   a_unlinked_latch: assert property (p_unlinked_latch) else $error("unlinked channel latch wrong");

   property p_ctrl_load;
      @(posedge clock) disable iff (!rst_n)
      (wr_now && addr_now == `AFE_ADDR_STATUS) |=> (comm_cfg == $past(acc_wdata[`AFE_CTRL_MSB:`AFE_CTRL_LSB]));
   endproperty
   a_ctrl_load: assert property (p_ctrl_load) else $error("control fields not stored");

   c_link: cover property (@(posedge clock) disable iff (!rst_n) link_fire);
   c_irq: cover property (@(posedge clock) disable iff (!rst_n) crc_irq ##[1:20] !crc_irq);
   c_restart: cover property (@(posedge clock) disable iff (!rst_n) adc_restart != '0);
   c_rearm: cover property (@(posedge clock) disable iff (!rst_n) status_read && ready_flags != `AFE_FLAGS_RESET);
   c_unlinked: cover property (@(posedge clock) disable iff (!rst_n) !comm_cfg.ready_link && data_latch != '0);
endmodule

// File: sim/afe_host_model.sv
// Host side of the register access port: one access per call
`timescale 1ns/1ps
`include "afe_regs_map.svh"
module afe_host_model (
   input wire logic clock, // System clock
   output logic acc_valid, // Access strobe
   output logic acc_start, // Load start address
   output logic [`AFE_ADDR_W-1:0] acc_addr, // Start address
   output logic acc_write, // Write when high
   output logic [23:0] acc_wdata, // Write data
   input wire logic [23:0] acc_rdata, // Read data
   input wire logic acc_rvalid // Read data valid
);
   initial begin
      acc_valid = 1'b0;
      acc_start = 1'b0;
      acc_addr = '0;
      acc_write = 1'b0;
      acc_wdata = 24'h00_0000;
   end

   // Strobe stays up after a call so a following call changes it once per time step; idle drops it
   task automatic access(input logic wr, input logic start, input logic [`AFE_ADDR_W-1:0] addr,
                         input logic [23:0] data, output logic [23:0] rd, output logic rv);
      acc_valid = 1'b1;
      acc_start = start;
      acc_addr = addr;
      acc_write = wr;
      acc_wdata = (addr == `AFE_ADDR_STATUS) ? (data & 24'hFF_CFFF) : data;
      @(posedge clock);
      #1;
      rd = acc_rdata;
      rv = acc_rvalid;
   endtask

   task automatic idle();
      acc_valid = 1'b0;
      acc_start = 1'b0;
   endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the phase, gain and status register group
`timescale 1ns/1ps
`include "afe_regs_map.svh"
module tb_top;
   import afe_regs_pkg::*;
   localparam int PULSE = 4;
   localparam int LIMIT = 5000;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic acc_valid, acc_start, acc_write, acc_rvalid, ready_pin_out, ready_pin_oe, crc_irq, rv;
   logic [4:0] acc_addr, cur_addr;
   logic [23:0] acc_wdata, acc_rdata, gain_log2, rd;
   logic [7:0] chan_active = 8'hFF;
   logic [7:0] chan_data_evt = 8'h00;
   logic cfg_crc_error = 1'b0;
   logic lock_write = 1'b0;
   logic [7:0] lock_value = 8'h00;
   logic [7:0] adc_restart, data_latch, ready_flags, seen_latch;
   logic [4:0] addrs [4] = '{5'h0B, 5'h0A, 5'h07, 5'h1F};
   logic [4:0] nexts [4] = '{5'h0B, 5'h08, 5'h00, 5'h00};
   logic [23:0] rexp [4] = '{24'hFA_C688, 24'hAB_C123, 24'h00_0000, 24'h00_0000};
   afe_phase_t phase;
   afe_comm_cfg_t comm_cfg;
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   int n;

   always #5 clock = ~clock;

   afe_host_model u_afe_host_model (.clock(clock), .acc_valid(acc_valid), .acc_start(acc_start),
      .acc_addr(acc_addr), .acc_write(acc_write), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
      .acc_rvalid(acc_rvalid));

   afe_regs #(.CHANNELS(8), .READY_PULSE_CYCLES(PULSE)) u_afe_regs (.clock(clock), .rst_n(rst_n),
      .acc_valid(acc_valid), .acc_start(acc_start), .acc_addr(acc_addr), .acc_write(acc_write),
      .acc_wdata(acc_wdata), .chan_active(chan_active), .chan_data_evt(chan_data_evt),
      .cfg_crc_error(cfg_crc_error), .lock_write(lock_write), .lock_value(lock_value),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .cur_addr(cur_addr), .phase(phase),
      .gain_log2(gain_log2), .comm_cfg(comm_cfg), .adc_restart(adc_restart), .data_latch(data_latch),
      .ready_flags(ready_flags), .ready_pin_out(ready_pin_out), .ready_pin_oe(ready_pin_oe), .crc_irq(crc_irq));

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step();
      u_afe_host_model.idle();
      @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [23:0] d, input logic start);
      u_afe_host_model.access(1'b1, start, a, d, rd, rv);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [23:0] exp);
      u_afe_host_model.access(1'b0, 1'b1, a, 24'h00_0000, rd, rv);
      check("read valid", rv, 1'b1);
      check("read data", rd, exp);
   endtask

   // Bits 11:8 and the flags are offered as ones; only the control field may stick
   task automatic wr_status(input logic [9:0] cfg);
      wr(5'h0C, {cfg, 6'h0F, 8'hFF}, 1'b1);
      check("comm_cfg", comm_cfg, cfg);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      repeat (10) @(posedge clock);
      #1;
      rst_n = 1'b1;
      step();
      check("comm_cfg reset", comm_cfg, 10'h2A4);
      check("flags reset", ready_flags, 8'hFF);
      check("pin oe reset", ready_pin_oe, 1'b0);
      check("gain reset", gain_log2, 24'h00_0000);
      rd_chk(5'h0C, 24'hA9_00FF);
      rd_chk(5'h0A, 24'h00_0000);
      rd_chk(5'h0D, 24'h00_0000);
      $display("test reset done");
      chan_active = 8'h5A;
      wr(5'h0A, 24'hAB_C123, 1'b1);
      check("delay 2/3", phase.delay_pair_2_3, 12'hABC);
      check("delay 0/1", phase.delay_pair_0_1, 12'h123);
      check("restart", adc_restart, 8'h5A);
      step();
      check("restart end", adc_restart, 8'h00);
      rd_chk(5'h0A, 24'hAB_C123);
      wr(5'h0B, 24'hFA_C688, 1'b1);
      step();
      check("gain map", gain_log2, 24'h02_C688);
      rd_chk(5'h0B, 24'hFA_C688);
      $display("test phase gain done");
      for (int i = 0; i < 4; i++) begin
         wr_status({i[1:0], 1'b1, 3'b000, i[1:0], 2'b00});
         rd_chk(addrs[i], rexp[i]);
         check("read step", cur_addr, nexts[i]);
      end
      wr_status(10'h29A);
      wr(5'h0A, 24'h12_3456, 1'b1);
      wr(5'h0B, 24'h00_0249, 1'b0);
      rd_chk(5'h0B, 24'h00_0249);
      wr(5'h1F, 24'hFF_FFFF, 1'b1);
      check("write loop", cur_addr, 5'h09);
      wr_status(10'h21A);
      wr(5'h0B, 24'h00_0000, 1'b1);
      check("write fixed", cur_addr, 5'h0B);
      wr_status(10'h29A);
      $display("test stepping done");
      chan_data_evt = 8'h08;
      step();
      chan_data_evt = 8'h00;
      check("latch", data_latch, 8'h08);
      step();
      check("flag clear", ready_flags, 8'hF7);
      for (int k = 0; k < PULSE; k++) begin
         check("pin low", {ready_pin_oe, ready_pin_out}, 2'b10);
         step();
      end
      check("pin released", ready_pin_oe, 1'b0);
      rd_chk(5'h03, 24'h00_0000);
      check("flag after data read", ready_flags, 8'hF7);
      rd_chk(5'h0C, {10'h29A, 6'h00, 8'hF7});
      step();
      check("flags set by read", ready_flags, 8'hFF);
      wr_status(10'h2DA);
      step();
      check("idle drive", {ready_pin_oe, ready_pin_out}, 2'b11);
      $display("test ready pin done");
      chan_active = 8'h03;
      wr_status(10'h2BA);
      n = 0;
      seen_latch = 8'h00;
      for (int k = 0; k < 8; k++) begin
         chan_data_evt = (k == 0) ? 8'h01 : ((k == 1) ? 8'h02 : 8'h00);
         step();
         if (data_latch !== 8'h00) begin
            n++;
            seen_latch = data_latch;
         end
      end
      check("linked pulses", n, 1);
      check("linked latch", seen_latch, 8'h03);
      $display("test linked done");
      cfg_crc_error = 1'b1;
      step();
      cfg_crc_error = 1'b0;
      step();
      step();
      check("irq disabled", {crc_irq, ready_pin_oe}, 2'b00);
      wr_status(10'h29B);
      cfg_crc_error = 1'b1;
      step();
      cfg_crc_error = 1'b0;
      check("irq set", crc_irq, 1'b1);
      step();
      check("pin held low", {ready_pin_oe, ready_pin_out}, 2'b10);
      lock_write = 1'b1;
      lock_value = 8'h5A;
      step();
      lock_write = 1'b0;
      step();
      step();
      check("wrong key", {crc_irq, ready_pin_out}, 2'b10);
      lock_write = 1'b1;
      lock_value = 8'hA5;
      step();
      lock_write = 1'b0;
      step();
      check("unlocked", crc_irq, 1'b0);
      $display("test checksum irq done");
      wrap_up();
   end
endmodule
